/* pfc_pkg.sv */
// Shared constants of the pause frame receive flow control block
package pfc_pkg;

    // --------------------------------------------------------------
    // Frame decode
    // --------------------------------------------------------------
    localparam logic [15:0] PFC_CTRL_TYPE  = 16'h8808;
    localparam logic [15:0] PFC_PAUSE_OPC  = 16'h0001;
    localparam logic [47:0] PFC_MC_ADDR    = 48'h0180C2000001;
    localparam logic [6:0]  PFC_CTRL_LEN   = 7'h40;
    localparam logic [6:0]  PFC_CNT_MAX    = 7'h7F;
    localparam logic [6:0]  PFC_POS_DA_END = 7'h06;
    localparam logic [6:0]  PFC_POS_TYPE_H = 7'h0C;
    localparam logic [6:0]  PFC_POS_TYPE_L = 7'h0D;
    localparam logic [6:0]  PFC_POS_OPC_H  = 7'h0E;
    localparam logic [6:0]  PFC_POS_OPC_L  = 7'h0F;
    localparam logic [6:0]  PFC_POS_PRM_H  = 7'h10;
    localparam logic [6:0]  PFC_POS_PRM_L  = 7'h11;
    localparam logic [15:0] PFC_PAUSE_MAX  = 16'hFFFF;
    localparam logic [15:0] PFC_PAUSE_ZERO = 16'h0000;

    // --------------------------------------------------------------
    // Timing: one quantum is 512 bit times, 51.2 ns at 10G
    // --------------------------------------------------------------
    localparam int PFC_QUANTUM_PS  = 51200;
    localparam int PFC_CLK_PS      = 4000;
    localparam int PFC_QUANTUM_CYC =
        (PFC_QUANTUM_PS + PFC_CLK_PS - 1) / PFC_CLK_PS;
    localparam int PFC_SUB_W       = $clog2(PFC_QUANTUM_CYC);
    localparam logic [PFC_SUB_W-1:0] PFC_SUB_MAX =
        PFC_SUB_W'(PFC_QUANTUM_CYC - 1);

    // --------------------------------------------------------------
    // Register map and events
    // --------------------------------------------------------------
    localparam int         PFC_ADDR_W     = 8;
    localparam logic [7:0] PFC_REG_CTRL   = 8'h00;
    localparam logic [7:0] PFC_REG_PA_LO  = 8'h04;
    localparam logic [7:0] PFC_REG_PA_HI  = 8'h08;
    localparam logic [7:0] PFC_REG_STATUS = 8'h0C;
    localparam logic [7:0] PFC_REG_CLEAR  = 8'h10;
    localparam logic [7:0] PFC_REG_IRQ_EN = 8'h14;
    localparam logic [7:0] PFC_REG_LEFT   = 8'h18;
    localparam logic       PFC_CTRL_RST   = 1'b1;
    localparam int         PFC_EV_N       = 3;
    localparam int         PFC_EV_PAUSE   = 0;
    localparam int         PFC_EV_CANCEL  = 1;
    localparam int         PFC_EV_BADCTL  = 2;
    localparam logic [1:0] PFC_RESP_OK    = 2'h0;
    localparam logic [1:0] PFC_RESP_ERR   = 2'h2;

    // --------------------------------------------------------------
    // Client example thresholds
    // --------------------------------------------------------------
    localparam int PFC_HI_NUM = 7;
    localparam int PFC_HI_DEN = 8;
    localparam int PFC_LO_NUM = 3;
    localparam int PFC_LO_DEN = 4;

endpackage

/* pfc_if.sv */
// Link between the MAC flow control end and its client end
`timescale 1ns/1ns
interface pfc_if;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_last;
    logic       rx_good;
    logic       rx_bad;
    logic       tx_req;
    logic       tx_end;
    logic       tx_ack;

    modport mac (
        output rx_valid, rx_data, rx_last, rx_good, rx_bad, tx_ack,
        input  tx_req, tx_end
    );
    modport client (
        input  rx_valid, rx_data, rx_last, rx_good, rx_bad, tx_ack,
        output tx_req, tx_end
    );
endinterface

/* pfc_mac_end.sv */
// MAC end: control frame checks, pause decode and transmit inhibit
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module pfc_mac_end
    import pfc_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [PFC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [PFC_ADDR_W-1:0] s_axi_araddr,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       irq,
    input  wire logic                  rx_in_valid,
    input  wire logic [7:0]            rx_in_data,
    input  wire logic                  rx_in_last,
    input  wire logic                  rx_in_err,
    pfc_if.mac                         lnk
);

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [6:0]           cnt;
        logic [47:0]          da;
        logic [15:0]          ltype;
        logic [15:0]          opc;
        logic [15:0]          prm;
        logic                 o_valid;
        logic [7:0]           o_data;
        logic                 o_last;
        logic                 o_good;
        logic                 o_bad;
        logic [15:0]          quanta;
        logic [PFC_SUB_W-1:0] sub;
        logic                 busy;
        logic                 ack;
        logic                 en;
        logic [47:0]          paddr;
        logic [PFC_EV_N-1:0]  sts;
        logic [PFC_EV_N-1:0]  ien;
        logic                 irq;
        logic                 awr;
        logic                 bv;
        logic [1:0]           br;
        logic                 arr;
        logic                 rv;
        logic [31:0]          rd;
        logic [1:0]           rr;
    } pfc_dev_st_t;

    localparam pfc_dev_st_t DEV_RST = '{en: PFC_CTRL_RST, default: '0};

    pfc_dev_st_t         st_r;
    pfc_dev_st_t         st_nxt;
    logic [PFC_EV_N-1:0] ev;
    logic [PFC_EV_N-1:0] clr;
    logic                is_ctl;
    logic                ok_ctl;
    logic                da_hit;

    function automatic logic [31:0] pfc_wmerge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        ev     = '0;
        clr    = '0;
        is_ctl = (st_r.ltype == PFC_CTRL_TYPE);
        // Last byte index 63 means exactly 64 bytes incl. FCS
        ok_ctl = !rx_in_err && (st_r.cnt == PFC_CTRL_LEN - 7'h01);
        da_hit = (st_r.da == PFC_MC_ADDR) || (st_r.da == st_r.paddr);

        st_nxt.ack     = 1'b0;
        st_nxt.o_valid = rx_in_valid;
        st_nxt.o_data  = rx_in_data;
        st_nxt.o_last  = rx_in_valid && rx_in_last;
        st_nxt.o_good  = 1'b0;
        st_nxt.o_bad   = 1'b0;

        // Quantum timer runs down the pause duration
        if (st_r.quanta != 16'h0000) begin
            if (st_r.sub == '0) begin
                st_nxt.quanta = st_r.quanta - 16'h0001;
                st_nxt.sub    = PFC_SUB_MAX;
            end else begin
                st_nxt.sub = st_r.sub - PFC_SUB_W'(1);
            end
        end

        if (rx_in_valid) begin
            if (st_r.cnt < PFC_POS_DA_END) begin
                st_nxt.da = {st_r.da[39:0], rx_in_data};
            end
            if (st_r.cnt == PFC_POS_TYPE_H || st_r.cnt == PFC_POS_TYPE_L) begin
                st_nxt.ltype = {st_r.ltype[7:0], rx_in_data};
            end
            if (st_r.cnt == PFC_POS_OPC_H || st_r.cnt == PFC_POS_OPC_L) begin
                st_nxt.opc = {st_r.opc[7:0], rx_in_data};
            end
            if (st_r.cnt == PFC_POS_PRM_H || st_r.cnt == PFC_POS_PRM_L) begin
                st_nxt.prm = {st_r.prm[7:0], rx_in_data};
            end
            if (st_r.cnt != PFC_CNT_MAX) begin
                st_nxt.cnt = st_r.cnt + 7'h01;
            end
            if (rx_in_last) begin
                st_nxt.cnt   = '0;
                st_nxt.ltype = '0;
                if (!is_ctl) begin
                    st_nxt.o_good = !rx_in_err;
                    st_nxt.o_bad  = rx_in_err;
                end else if (!ok_ctl) begin
                    st_nxt.o_bad     = 1'b1;
                    ev[PFC_EV_BADCTL] = 1'b1;
                end else if (!st_r.en) begin
                    st_nxt.o_good = 1'b1;
                end else if (!da_hit || st_r.opc != PFC_PAUSE_OPC) begin
                    st_nxt.o_good = 1'b1;
                end else begin
                    // Reload also cancels; zero ends the pause now
                    st_nxt.quanta    = st_r.prm;
                    st_nxt.sub       = PFC_SUB_MAX;
                    st_nxt.o_bad     = 1'b1;
                    ev[PFC_EV_PAUSE] = 1'b1;
                    ev[PFC_EV_CANCEL] = (st_r.prm == PFC_PAUSE_ZERO);
                end
            end
        end

        // Acks only between frames, so a running frame completes
        if (lnk.tx_end) begin
            st_nxt.busy = 1'b0;
        end
        if (lnk.tx_req && !st_r.busy && !st_r.ack
                && st_r.quanta == 16'h0000) begin
            st_nxt.ack  = 1'b1;
            st_nxt.busy = 1'b1;
        end

        // Write channel: address and data are taken together
        st_nxt.awr = 1'b0;
        if (s_axi_awvalid && s_axi_wvalid && !st_r.awr && !st_r.bv) begin
            st_nxt.awr = 1'b1;
        end
        if (st_r.awr) begin
            st_nxt.bv = 1'b1;
            st_nxt.br = PFC_RESP_OK;
            case (s_axi_awaddr)
                PFC_REG_CTRL: begin
                    if (s_axi_wstrb[0]) begin
                        st_nxt.en = s_axi_wdata[0];
                    end
                end
                PFC_REG_PA_LO: begin
                    st_nxt.paddr[31:0] = pfc_wmerge(st_r.paddr[31:0],
                        s_axi_wdata, s_axi_wstrb);
                end
                PFC_REG_PA_HI: begin
                    st_nxt.paddr[47:32] = 16'(pfc_wmerge(
                        {16'h0000, st_r.paddr[47:32]},
                        s_axi_wdata, s_axi_wstrb));
                end
                PFC_REG_CLEAR: begin
                    if (s_axi_wstrb[0]) begin
                        clr = s_axi_wdata[PFC_EV_N-1:0];
                    end
                end
                PFC_REG_IRQ_EN: begin
                    if (s_axi_wstrb[0]) begin
                        st_nxt.ien = s_axi_wdata[PFC_EV_N-1:0];
                    end
                end
                PFC_REG_STATUS, PFC_REG_LEFT: begin
                end
                default: begin
                    st_nxt.br = PFC_RESP_ERR;
                end
            endcase
        end
        if (st_r.bv && s_axi_bready) begin
            st_nxt.bv = 1'b0;
        end

        // A new event wins over a clear in the same cycle
        st_nxt.sts = (st_r.sts & ~clr) | ev;
        st_nxt.irq = |(st_nxt.sts & st_nxt.ien);

        // Read channel
        st_nxt.arr = 1'b0;
        if (s_axi_arvalid && !st_r.arr && !st_r.rv) begin
            st_nxt.arr = 1'b1;
        end
        if (st_r.arr) begin
            st_nxt.rv = 1'b1;
            st_nxt.rr = PFC_RESP_OK;
            st_nxt.rd = '0;
            case (s_axi_araddr)
                PFC_REG_CTRL:   st_nxt.rd[0] = st_r.en;
                PFC_REG_PA_LO:  st_nxt.rd = st_r.paddr[31:0];
                PFC_REG_PA_HI:  st_nxt.rd[15:0] = st_r.paddr[47:32];
                PFC_REG_STATUS: st_nxt.rd[PFC_EV_N-1:0] = st_r.sts;
                PFC_REG_CLEAR:  st_nxt.rd = '0;
                PFC_REG_IRQ_EN: st_nxt.rd[PFC_EV_N-1:0] = st_r.ien;
                PFC_REG_LEFT: begin
                    st_nxt.rd[15:0] = st_r.quanta;
                    st_nxt.rd[31]   = st_r.busy;
                end
                default:        st_nxt.rr = PFC_RESP_ERR;
            endcase
        end
        if (st_r.rv && s_axi_rready) begin
            st_nxt.rv = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= DEV_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign s_axi_awready = st_r.awr;
    assign s_axi_wready  = st_r.awr;
    assign s_axi_bvalid  = st_r.bv;
    assign s_axi_bresp   = st_r.br;
    assign s_axi_arready = st_r.arr;
    assign s_axi_rvalid  = st_r.rv;
    assign s_axi_rdata   = st_r.rd;
    assign s_axi_rresp   = st_r.rr;
    assign irq           = st_r.irq;
    assign lnk.rx_valid  = st_r.o_valid;
    assign lnk.rx_data   = st_r.o_data;
    assign lnk.rx_last   = st_r.o_last;
    assign lnk.rx_good   = st_r.o_good;
    assign lnk.rx_bad    = st_r.o_bad;
    assign lnk.tx_ack    = st_r.ack;

endmodule

/* pfc_client_end.sv */
// Client end: control frame discard, local pause, FIFO pause requests
`timescale 1ns/1ns
module pfc_client_end
    import pfc_pkg::*;
#(
    parameter int LVL_W = 10,
    parameter int DEPTH = 1024
)
(
    input  wire logic           mclk,
    input  wire logic           rst_n,
    pfc_if.client               lnk,
    input  wire logic           usr_fc_local,
    input  wire logic [LVL_W:0] fifo_level,
    input  wire logic           usr_tx_go,
    input  wire logic           usr_tx_done,
    output logic                usr_tx_busy,
    output logic                usr_rx_valid,
    output logic [7:0]          usr_rx_data,
    output logic                usr_rx_last,
    output logic                usr_rx_keep,
    output logic                ctl_dropped,
    output logic                pause_req,
    output logic [15:0]         pause_val
);

    localparam logic [LVL_W:0] HI_LVL =
        (LVL_W+1)'(DEPTH * PFC_HI_NUM / PFC_HI_DEN);
    localparam logic [LVL_W:0] LO_LVL =
        (LVL_W+1)'(DEPTH * PFC_LO_NUM / PFC_LO_DEN);

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [6:0]           cnt;
        logic [15:0]          ltype;
        logic [15:0]          opc;
        logic [15:0]          prm;
        logic                 rv;
        logic [7:0]           rd;
        logic                 rl;
        logic                 keep;
        logic                 drop;
        logic [15:0]          quanta;
        logic [PFC_SUB_W-1:0] sub;
        logic                 pend;
        logic                 busy;
        logic                 txb;
        logic                 tx_req;
        logic                 tx_end;
        logic                 hold;
        logic                 preq;
        logic [15:0]          pval;
    } pfc_cli_st_t;

    pfc_cli_st_t st_r;
    pfc_cli_st_t st_nxt;
    logic        is_ctl;

    always_comb begin
        st_nxt      = st_r;
        is_ctl      = (st_r.ltype == PFC_CTRL_TYPE);
        st_nxt.rv   = lnk.rx_valid;
        st_nxt.rd   = lnk.rx_data;
        st_nxt.rl   = lnk.rx_valid && lnk.rx_last;
        st_nxt.keep = 1'b0;
        st_nxt.drop = 1'b0;
        st_nxt.preq = 1'b0;

        if (st_r.quanta != 16'h0000) begin
            if (st_r.sub == '0) begin
                st_nxt.quanta = st_r.quanta - 16'h0001;
                st_nxt.sub    = PFC_SUB_MAX;
            end else begin
                st_nxt.sub = st_r.sub - PFC_SUB_W'(1);
            end
        end

        if (lnk.rx_valid) begin
            if (st_r.cnt == PFC_POS_TYPE_H || st_r.cnt == PFC_POS_TYPE_L) begin
                st_nxt.ltype = {st_r.ltype[7:0], lnk.rx_data};
            end
            if (st_r.cnt == PFC_POS_OPC_H || st_r.cnt == PFC_POS_OPC_L) begin
                st_nxt.opc = {st_r.opc[7:0], lnk.rx_data};
            end
            if (st_r.cnt == PFC_POS_PRM_H || st_r.cnt == PFC_POS_PRM_L) begin
                st_nxt.prm = {st_r.prm[7:0], lnk.rx_data};
            end
            if (st_r.cnt != PFC_CNT_MAX) begin
                st_nxt.cnt = st_r.cnt + 7'h01;
            end
            if (lnk.rx_last) begin
                st_nxt.cnt   = '0;
                st_nxt.ltype = '0;
                st_nxt.keep  = lnk.rx_good && !is_ctl;
                st_nxt.drop  = is_ctl;
                // Device flow control off: this end acts on pauses
                if (is_ctl && lnk.rx_good && usr_fc_local
                        && st_r.opc == PFC_PAUSE_OPC) begin
                    st_nxt.quanta = st_r.prm;
                    st_nxt.sub    = PFC_SUB_MAX;
                end
            end
        end

        // Hysteresis keeps a single pause outstanding per fill cycle
        if (!st_r.hold && fifo_level > HI_LVL) begin
            st_nxt.preq = 1'b1;
            st_nxt.pval = PFC_PAUSE_MAX;
            st_nxt.hold = 1'b1;
        end else if (st_r.hold && fifo_level < LO_LVL) begin
            st_nxt.preq = 1'b1;
            st_nxt.pval = PFC_PAUSE_ZERO;
            st_nxt.hold = 1'b0;
        end

        st_nxt.tx_end = st_r.busy && usr_tx_done;
        if (st_r.busy && usr_tx_done) begin
            st_nxt.busy = 1'b0;
        end
        if (usr_tx_go) begin
            st_nxt.pend = 1'b1;
        end
        if (lnk.tx_ack) begin
            st_nxt.pend = 1'b0;
            st_nxt.busy = 1'b1;
        end
        st_nxt.tx_req = st_nxt.pend && !st_nxt.busy
                        && st_nxt.quanta == 16'h0000;
        st_nxt.txb    = st_nxt.pend || st_nxt.busy;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lnk.tx_req   = st_r.tx_req;
    assign lnk.tx_end   = st_r.tx_end;
    assign usr_tx_busy  = st_r.txb;
    assign usr_rx_valid = st_r.rv;
    assign usr_rx_data  = st_r.rd;
    assign usr_rx_last  = st_r.rl;
    assign usr_rx_keep  = st_r.keep;
    assign ctl_dropped  = st_r.drop;
    assign pause_req    = st_r.preq;
    assign pause_val    = st_r.pval;

endmodule

/* pfc_props.sv */
// Checker of the link between the MAC end and the client end
`timescale 1ns/1ns
module pfc_props
    import pfc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       rx_last,
    input wire logic       rx_good,
    input wire logic       rx_bad,
    input wire logic       tx_req,
    input wire logic       tx_end,
    input wire logic       tx_ack
);
    logic [6:0]  idx_r;
    logic [15:0] typ_r;
    logic [31:0] fld_r;
    logic        busy_r;
    logic        ctl;
    assign ctl = rx_last && typ_r == PFC_CTRL_TYPE;
    // Byte index and header fields seen on the link
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx_r <= '0;
            typ_r <= '0;
            fld_r <= '0;
        end else if (rx_valid) begin
            idx_r <= rx_last ? 7'h00 : idx_r + 7'(idx_r != 7'h7F);
            if (idx_r == 7'h0C || idx_r == 7'h0D)
                typ_r <= {typ_r[7:0], rx_data};
            if (idx_r >= 7'h0E && idx_r <= 7'h11)
                fld_r <= {fld_r[23:0], rx_data};
            if (rx_last)
                typ_r <= '0;
        end
    end
    // Granted frame running until its end pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            busy_r <= 1'b0;
        else if (tx_ack)
            busy_r <= 1'b1;
        else if (tx_end)
            busy_r <= 1'b0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_VERDICT_LAST: assert property ((rx_good || rx_bad) |-> rx_last && rx_valid)
        else $error("verdict outside last byte");
    AST_VERDICT_ONE: assert property (rx_last |-> rx_good != rx_bad)
        else $error("frame without single verdict");
    AST_CTRL_LEN: assert property (ctl && idx_r != 7'h3F |-> rx_bad)
        else $error("short or long control frame not rejected");
    AST_PAUSE_HOLD: assert property (ctl && rx_bad && idx_r == 7'h3F
        && fld_r[31:16] == PFC_PAUSE_OPC && fld_r[15:0] != 16'h0000
        |=> !tx_ack [*8])
        else $error("grant during pause");
    AST_ACK_PULSE: assert property (tx_ack |=> !tx_ack)
        else $error("grant longer than one cycle");
    AST_ACK_REQ: assert property (tx_ack |-> $past(tx_req))
        else $error("grant without request");
    AST_ACK_BUSY: assert property (busy_r |-> !tx_ack)
        else $error("grant while frame running");
    AST_ACK_GAP: assert property (tx_end |=> !tx_ack)
        else $error("grant right after frame end");
endmodule

/* pfc_bench.sv */
// Bench of the flow control block: both ends joined by the link
`timescale 1ns/1ns
module pfc_bench
    import pfc_pkg::*;
;
    localparam int QC = PFC_QUANTUM_CYC;
    localparam logic [47:0] MC = PFC_MC_ADDR;
    localparam logic [15:0] CT = PFC_CTRL_TYPE;
    logic mclk = 0, rst_n = 0, awv = 0, wv = 0, br = 1, arv = 0, rr = 1;
    logic [7:0] awa = 0, ara = 0, rxd = 0, urd;
    logic [31:0] wd = 0, rdata;
    logic awr, wrd, bv, arr, rv, irq, busy, urv, url, keep, cd, preq;
    logic [1:0] bresp, rresp;
    logic rxv = 0, rxl = 0, rxe = 0, go = 0, done = 0, loc = 0;
    logic [10:0] lvl = 0;
    logic [15:0] pval;
    logic vg, vb, vk, vc;
    logic [8:0] vd;
    int err_count = 0, total_checks = 0;
    pfc_if pfc_if_i ();
    pfc_mac_end pfc_mac_end_i (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .irq(irq),
        .rx_in_valid(rxv), .rx_in_data(rxd), .rx_in_last(rxl),
        .rx_in_err(rxe), .lnk(pfc_if_i));
    pfc_client_end pfc_client_end_i (.mclk(mclk), .rst_n(rst_n),
        .lnk(pfc_if_i), .usr_fc_local(loc), .fifo_level(lvl),
        .usr_tx_go(go), .usr_tx_done(done), .usr_tx_busy(busy),
        .usr_rx_valid(urv), .usr_rx_data(urd), .usr_rx_last(url),
        .usr_rx_keep(keep), .ctl_dropped(cd), .pause_req(preq),
        .pause_val(pval));
    pfc_props pfc_props_i (.mclk(mclk), .rst_n(rst_n),
        .rx_valid(pfc_if_i.rx_valid), .rx_data(pfc_if_i.rx_data),
        .rx_last(pfc_if_i.rx_last), .rx_good(pfc_if_i.rx_good),
        .rx_bad(pfc_if_i.rx_bad), .tx_req(pfc_if_i.tx_req),
        .tx_end(pfc_if_i.tx_end), .tx_ack(pfc_if_i.tx_ack));
    initial begin
        forever #2 mclk = ~mclk;
    end
    // Latch verdicts so checks need not hit the one-cycle pulses
    always @(posedge mclk) begin
        if (pfc_if_i.rx_last) begin
            vg <= pfc_if_i.rx_good;
            vb <= pfc_if_i.rx_bad;
        end
        if (url) begin
            vk <= keep;
            vc <= cd;
            vd <= {urv, urd};
        end
    end
    task end_of_test;
        $display("mismatches %0d checks %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [33:0] g, input logic [33:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) break;
        end
        chk(bresp, r, "write response");
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        chk({rresp, rdata}, {r, d}, "read data");
    endtask
    // Header bytes first, zero padding; the caller holds rxe for the whole frame
    task fr(input logic [47:0] da, input logic [15:0] ty,
            input logic [15:0] op, input logic [15:0] pr, input int n);
        logic [143:0] h;
        h = {da, 48'h02AAAAAAAAAA, ty, op, pr};
        for (int i = 0; i < n; i++) begin
            rxv <= 1'b1;
            rxd <= i < 18 ? h[143-8*i -: 8] : 8'h00;
            rxl <= i == n - 1;
            @(posedge mclk);
        end
        rxv <= 1'b0;
        rxl <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task tx(input int lo, input int hi);
        int c;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        c = 0;
        while (pfc_if_i.tx_ack !== 1'b1 && c < 2000) begin
            @(posedge mclk);
            c++;
        end
        chk({c >= lo && c <= hi, busy}, 2'b11, "grant delay");
        done <= 1'b1;
        @(posedge mclk);
        done <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task t_len;
        rd(PFC_REG_CTRL, 1, PFC_RESP_OK);
        rd(8'hFC, 0, PFC_RESP_ERR);
        wr(8'hFC, 0, PFC_RESP_ERR);
        wr(PFC_REG_IRQ_EN, 7, PFC_RESP_OK);
        fr(MC, CT, PFC_PAUSE_OPC, 16'h0002, 60);
        chk({vg, vb}, 2'b01, "short control frame");
        rxe <= 1'b1;
        fr(MC, CT, PFC_PAUSE_OPC, 16'h0002, 64);
        rxe <= 1'b0;
        chk({vg, vb}, 2'b01, "bad FCS");
        rd(PFC_REG_STATUS, 4, PFC_RESP_OK);
        wr(PFC_REG_CLEAR, 7, PFC_RESP_OK);
    endtask
    task t_pause;
        fr(MC, CT, PFC_PAUSE_OPC, 16'h0002, 64);
        chk({vg, vb, vc, irq}, 4'b0111, "pause verdict");
        tx(QC * 2 - 8, QC * 2 + 4);
        rd(PFC_REG_STATUS, 1, PFC_RESP_OK);
        wr(PFC_REG_CLEAR, 7, PFC_RESP_OK);
        chk(irq, 0, "irq after clear");
        fr(MC, CT, PFC_PAUSE_OPC, PFC_PAUSE_MAX, 64);
        rd(PFC_REG_LEFT, 32'h0000FFFF, PFC_RESP_OK);
        fr(MC, CT, PFC_PAUSE_OPC, PFC_PAUSE_ZERO, 64);
        tx(0, 6);
        rd(PFC_REG_STATUS, 3, PFC_RESP_OK);
        wr(PFC_REG_CLEAR, 7, PFC_RESP_OK);
    endtask
    task t_decode;
        fr(MC, CT, 16'h0002, 16'h0040, 64);
        chk({vg, vb, vc}, 3'b101, "other opcode");
        wr(PFC_REG_PA_LO, 32'h33445566, PFC_RESP_OK);
        wr(PFC_REG_PA_HI, 32'h00001122, PFC_RESP_OK);
        fr(48'h112233445567, CT, PFC_PAUSE_OPC, 16'h0040, 64);
        chk({vg, vb}, 2'b10, "foreign address");
        fr(MC, 16'h0800, PFC_PAUSE_OPC, 16'h0040, 16);
        chk({vg, vb, vk, vd}, {3'b101, 9'h101}, "plain");
        tx(0, 6);
        fr(48'h112233445566, CT, PFC_PAUSE_OPC, 16'h0000, 64);
        chk({vg, vb}, 2'b01, "pause address");
        wr(PFC_REG_CTRL, 0, PFC_RESP_OK);
        fr(MC, CT, PFC_PAUSE_OPC, 16'h0040, 64);
        chk({vg, vb}, 2'b10, "pause off");
        tx(0, 6);
        loc <= 1'b1;
        fr(MC, CT, PFC_PAUSE_OPC, 16'h0002, 64);
        tx(QC * 2 - 8, QC * 2 + 4);
    endtask
    task t_fifo;
        lvl <= 11'(1024 * PFC_HI_NUM / PFC_HI_DEN + 1);
        repeat (2) @(posedge mclk);
        chk({preq, pval}, {1'b1, PFC_PAUSE_MAX}, "high");
        lvl <= 11'(1024 * PFC_LO_NUM / PFC_LO_DEN - 1);
        repeat (2) @(posedge mclk);
        chk({preq, pval}, {1'b1, PFC_PAUSE_ZERO}, "low");
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_len();
        t_pause();
        t_decode();
        t_fifo();
        end_of_test();
    end
    // Whole run takes under a thousand cycles
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
endmodule
